// ===== shared/cfg_loader_defines.vh
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_LEN           8'h04
`define REG_ADDR          8'h08
`define REG_STATUS        8'h0C
`define REG_DATA          8'h10
`define REG_COUNT         8'h14

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define SEL_CTRL          3'h0
`define SEL_LEN           3'h1
`define SEL_ADDR          3'h2
`define SEL_STATUS        3'h3
`define SEL_DATA          3'h4
`define SEL_COUNT         3'h5
`define SEL_NONE          3'h7

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_INIT_DONE_EN 0
`define CTRL_CLEAR_EN     1
`define CTRL_OE_EN        2
`define CTRL_USER_CLK_EN  3
`define CTRL_MASK         32'h0000_000F
`define STS_ABORT         12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST          32'h0000_0000
`define LEN_RST           16'h0100
`define ADDR_RST          24'h00_0000

// ----------------------------------------------------------------
// modes, commands, timing, responses, sync width
// ----------------------------------------------------------------
`define MODE_AS           2'h0
`define MODE_PS           2'h1
`define CMD_READ          8'h03
`define HDR_BITS          17'h0_0020
`define DIV_HALF          3'h3
`define INIT_CYCLES       8'h10
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define SYNC_W            9

`endif

// ===== rtl/cfg_pin_sync.v
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"

// two-stage synchroniser, one chain per bit
module cfg_pin_sync #(
  parameter WIDTH = `SYNC_W
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge clk) begin
        if (!rst_n) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate

endmodule // cfg_pin_sync

// ===== rtl/config_chain_and_global_override_pins.v
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"

module config_chain_and_global_override_pins (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  input  wire        cfg_restart_n,
  input  wire        chain_enable_in_n,
  output wire        chain_enable_out_n,
  input  wire [1:0]  cfg_mode_select,
  input  wire        cfg_serial_clock_in,
  output wire        cfg_serial_clock_out,
  output wire        cfg_serial_clock_oe_n,
  input  wire        cfg_data_in,
  output wire        serial_cfg_data_out,
  output wire        serial_cfg_data_out_oe_n,
  output wire        cfg_mem_select_n,
  output wire        cfg_mem_select_oe_n,
  output wire        serial_pins_user_io,
  output wire        init_done_out,
  output wire        init_done_oe_n,
  input  wire        user_init_clock,
  output wire        init_pins_user_io,
  input  wire        global_clear_n,
  input  wire        global_output_enable,
  output wire        clear_all_regs,
  output wire        io_tristate_all
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_LOAD  = 3'h2;
  localparam [2:0] ST_INIT  = 3'h3;
  localparam [2:0] ST_USER  = 3'h4;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `REG_CTRL:   reg_sel = `SEL_CTRL;
        `REG_LEN:    reg_sel = `SEL_LEN;
        `REG_ADDR:   reg_sel = `SEL_ADDR;
        `REG_STATUS: reg_sel = `SEL_STATUS;
        `REG_DATA:   reg_sel = `SEL_DATA;
        `REG_COUNT:  reg_sel = `SEL_COUNT;
        default:     reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = dat[k*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [`SYNC_W-1:0] pin_s;
  wire               rst_s;
  wire               ce_s;
  wire [1:0]         msel_s;
  wire               sclk_s;
  wire               din_s;
  wire               uclk_s;
  wire               gclr_s;
  wire               goe_s;

  cfg_pin_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     ({global_output_enable, global_clear_n, user_init_clock,
             cfg_data_in, cfg_serial_clock_in, cfg_mode_select,
             chain_enable_in_n, cfg_restart_n}),
    .q     (pin_s)
  );

  assign {goe_s, gclr_s, uclk_s, din_s, sclk_s, msel_s, ce_s, rst_s} = pin_s;

  reg  [2:0]  prev_ff;
  wire        rst_rise;
  wire        sclk_rise;
  wire        uclk_rise;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= 3'h0;
    end else begin
      prev_ff <= {uclk_s, sclk_s, rst_s};
    end
  end

  assign rst_rise  = rst_s & ~prev_ff[0];
  assign sclk_rise = sclk_s & ~prev_ff[1];
  assign uclk_rise = uclk_s & ~prev_ff[2];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_ff;
  reg  [15:0] len_ff;
  reg  [23:0] addr_ff;
  reg  [31:0] data_ff;
  reg  [15:0] count_ff;
  reg         abort_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [1:0]  mode_ff;

  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rd_mux;

  wire        wr_fire = aw_got_ff & w_got_ff;
  wire [31:0] len_wr  = merge({16'h0000, len_ff}, wdata_ff, wstrb_ff);
  wire [31:0] addr_wr = merge({8'h00, addr_ff}, wdata_ff, wstrb_ff);
  wire [2:0]  wr_sel  = reg_sel(awaddr_ff);
  wire [2:0]  rd_sel  = reg_sel(araddr);
  wire [31:0] status  = {19'h0_0000, abort_ff, 1'b0, rst_s, ce_s,
                         (state_ff == ST_USER), 2'h0, mode_ff, 1'b0, state_ff};

  assign awready = ~aw_got_ff & ~bvalid_ff;
  assign wready  = ~w_got_ff & ~bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid & wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_ff & bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // status, data and count are read-only; abort clears by writing one
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `CTRL_RST;
      len_ff  <= `LEN_RST;
      addr_ff <= `ADDR_RST;
    end else if (wr_fire) begin
      case (wr_sel)
        `SEL_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & `CTRL_MASK;
        `SEL_LEN:  len_ff  <= len_wr[15:0];
        `SEL_ADDR: addr_ff <= addr_wr[23:0];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (rd_sel)
      `SEL_CTRL:   rd_mux = ctrl_ff;
      `SEL_LEN:    rd_mux = {16'h0000, len_ff};
      `SEL_ADDR:   rd_mux = {8'h00, addr_ff};
      `SEL_STATUS: rd_mux = status;
      `SEL_DATA:   rd_mux = data_ff;
      `SEL_COUNT:  rd_mux = {16'h0000, count_ff};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (arvalid & arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_ff & rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serial transfer
  // ----------------------------------------------------------------
  reg  [2:0]  div_cnt_ff;
  reg         sclk_ff;
  reg  [16:0] bit_cnt_ff;
  reg  [31:0] shift_out_ff;
  reg  [7:0]  init_cnt_ff;

  wire        as_mode   = (mode_ff == `MODE_AS);
  wire        div_tick  = (div_cnt_ff == `DIV_HALF);
  wire [16:0] target    = as_mode ? ({1'b0, len_ff} + `HDR_BITS) : {1'b0, len_ff};
  wire        load_done = (bit_cnt_ff == target);
  wire        bit_rise  = ~load_done & (as_mode ? (div_tick & ~sclk_ff) : sclk_rise);
  wire        bit_fall  = as_mode & div_tick & sclk_ff;
  wire        capture   = ~as_mode | (bit_cnt_ff >= `HDR_BITS);
  wire        init_tick = ctrl_ff[`CTRL_USER_CLK_EN] ? uclk_rise : 1'b1;
  wire        init_done = (init_cnt_ff == `INIT_CYCLES);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff   <= 3'h0;
      sclk_ff      <= 1'b0;
      bit_cnt_ff   <= 17'h0_0000;
      shift_out_ff <= 32'h0000_0000;
      data_ff      <= 32'h0000_0000;
    end else if (state_ff != ST_LOAD) begin
      div_cnt_ff   <= 3'h0;
      sclk_ff      <= 1'b0;
      bit_cnt_ff   <= 17'h0_0000;
      shift_out_ff <= {`CMD_READ, addr_ff};
    end else begin
      if (as_mode & ~load_done) begin
        div_cnt_ff <= div_tick ? 3'h0 : div_cnt_ff + 3'h1;
        if (div_tick) begin
          sclk_ff <= ~sclk_ff;
        end
      end
      if (bit_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 17'h0_0001;
        if (capture) begin
          data_ff <= {data_ff[30:0], din_s};
        end
      end
      if (bit_fall) begin
        shift_out_ff <= {shift_out_ff[30:0], 1'b0};
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      init_cnt_ff <= 8'h00;
    end else if (state_ff != ST_INIT) begin
      init_cnt_ff <= 8'h00;
    end else if (init_tick & ~init_done) begin
      init_cnt_ff <= init_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // configuration sequence
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (rst_rise) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!ce_s) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (ce_s) begin
          nxt_state = ST_WAIT;
        end else if (load_done) begin
          nxt_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (ce_s) begin
          nxt_state = ST_WAIT;
        end else if (init_done) begin
          nxt_state = ST_USER;
        end
      end
      ST_USER: begin
        nxt_state = ST_USER;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
    if (!rst_s) begin
      nxt_state = ST_RESET;
    end
  end

  wire abort_set = ce_s & ((state_ff == ST_LOAD) | (state_ff == ST_INIT));
  wire abort_clr = wr_fire & (wr_sel == `SEL_STATUS) & wstrb_ff[1] & wdata_ff[`STS_ABORT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_RESET;
      mode_ff  <= `MODE_AS;
      count_ff <= 16'h0000;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == ST_RESET) & rst_rise) begin
        mode_ff <= msel_s;
      end
      if ((state_ff == ST_INIT) & (nxt_state == ST_USER)) begin
        count_ff <= count_ff + 16'h0001;
      end
      if (abort_set) begin
        abort_ff <= 1'b1;
      end else if (abort_clr) begin
        abort_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------
  reg  cs_n_ff;
  reg  as_drive_ff;
  reg  ce_out_n_ff;
  reg  init_oe_n_ff;
  reg  clear_ff;
  reg  tri_ff;
  wire loading_as = (nxt_state == ST_LOAD) & (mode_ff == `MODE_AS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cs_n_ff      <= 1'b1;
      as_drive_ff  <= 1'b0;
      ce_out_n_ff  <= 1'b1;
      init_oe_n_ff <= 1'b1;
      clear_ff     <= 1'b0;
      tri_ff       <= 1'b1;
    end else begin
      cs_n_ff      <= ~(loading_as & ~load_done);
      as_drive_ff  <= loading_as;
      ce_out_n_ff  <= ~(nxt_state == ST_USER);
      init_oe_n_ff <= ~(ctrl_ff[`CTRL_INIT_DONE_EN] & (nxt_state != ST_USER) &
                        (nxt_state != ST_RESET));
      clear_ff     <= ctrl_ff[`CTRL_CLEAR_EN] & ~gclr_s;
      tri_ff       <= ~rst_s | (ctrl_ff[`CTRL_OE_EN] & ~goe_s) |
                      (nxt_state != ST_USER);
    end
  end

  assign cfg_mem_select_n         = cs_n_ff;
  assign cfg_mem_select_oe_n      = ~as_drive_ff;
  assign serial_cfg_data_out      = shift_out_ff[31];
  assign serial_cfg_data_out_oe_n = ~as_drive_ff;
  assign serial_pins_user_io      = (mode_ff != `MODE_AS) | (state_ff == ST_USER);
  assign cfg_serial_clock_out     = sclk_ff;
  assign cfg_serial_clock_oe_n    = ~as_drive_ff;
  assign chain_enable_out_n       = ce_out_n_ff;
  assign init_done_out            = 1'b0;
  assign init_done_oe_n           = init_oe_n_ff;
  assign init_pins_user_io        = (state_ff == ST_USER) |
                                    ~ctrl_ff[`CTRL_INIT_DONE_EN];
  assign clear_all_regs           = clear_ff;
  assign io_tristate_all          = tri_ff;

endmodule // config_chain_and_global_override_pins

// ===== dv/cfg_memory_model.sv
`timescale 1ns/1ps
// serial configuration memory: takes command and address, then streams a word
module cfg_memory_model #(
  parameter logic [31:0] WORD = 32'hA5C3_0F96
) (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic [31:0]      header
);
  int unsigned n_bits;
  initial begin
    dout = 1'b0;
    header = 32'h0;
    n_bits = 0;
  end
  always @(negedge cs_n) begin
    n_bits = 0;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      if (n_bits < 32) header = {header[30:0], din};
      n_bits++;
    end
  end
  // data changes on the falling clock; an idle or deselected line keeps flipping
  always @(negedge sck or posedge cs_n) begin
    if (!cs_n && n_bits >= 32 && n_bits < 64) dout <= WORD[63-n_bits];
    else dout <= ~dout;
  end
endmodule // cfg_memory_model

// ===== dv/cfg_pins_monitor.sv
`timescale 1ns/1ps
module cfg_pins_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cfg_restart_n,
  input wire logic chain_enable_in_n,
  input wire logic chain_enable_out_n,
  input wire logic cfg_serial_clock_out,
  input wire logic cfg_serial_clock_oe_n,
  input wire logic serial_cfg_data_out,
  input wire logic serial_cfg_data_out_oe_n,
  input wire logic cfg_mem_select_n,
  input wire logic cfg_mem_select_oe_n,
  input wire logic serial_pins_user_io,
  input wire logic init_done_oe_n,
  input wire logic init_pins_user_io,
  input wire logic global_clear_n,
  input wire logic clear_all_regs,
  input wire logic io_tristate_all
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ce_gate: assert property (
    chain_enable_in_n [*5] |-> cfg_mem_select_n)
    else $error("memory selected while chain input disabled");
  chk_user_entry: assert property (
    $fell(chain_enable_out_n) |-> init_pins_user_io && init_done_oe_n && cfg_mem_select_n)
    else $error("user mode entered with pins still held");
  chk_data_hold: assert property (
    cfg_serial_clock_out && !cfg_mem_select_n |-> $stable(serial_cfg_data_out))
    else $error("serial data changed while clock high");
  chk_select_driven: assert property (
    !cfg_mem_select_n |-> !cfg_mem_select_oe_n)
    else $error("memory select low but not driven");
  chk_ps_release: assert property (
    serial_pins_user_io |-> cfg_mem_select_oe_n && serial_cfg_data_out_oe_n)
    else $error("serial pins driven while released");
  chk_clear_lag: assert property (
    clear_all_regs |-> !$past(global_clear_n, 3))
    else $error("clear without clear pin low");
  chk_restart_hold: assert property (
    !cfg_restart_n [*5] |-> io_tristate_all && chain_enable_out_n)
    else $error("restart low without tristate");
  chk_clock_dir: assert property (
    !cfg_serial_clock_oe_n |-> !serial_pins_user_io)
    else $error("clock driven outside active load");
  chk_select_idle: assert property (
    cfg_mem_select_oe_n |-> cfg_mem_select_n)
    else $error("memory select low while idle");
endmodule // cfg_pins_monitor

// ===== dv/config_chain_and_global_override_pins_bench.sv
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module config_chain_and_global_override_pins_bench;
  localparam logic [31:0] MEM_WORD = 32'hA5C3_0F96;
  localparam logic [31:0] PS_WORD  = 32'h3C5A_96E1;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, cfg_restart_n = 1, chain_enable_in_n = 1, ps_clk = 0, ps_data = 0;
  logic        uclk = 0, glob_clr_n = 1, glob_oe = 1, awready, wready, bvalid, arready, rvalid;
  logic        mem_dout, sck, sck_oe_n, sdo, sdo_oe_n, cs_n, cs_oe_n, ser_user, ido, ido_oe_n;
  logic        init_user, ceo_n, clr_all, tri_all;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [1:0]  bresp, rresp, rs, cfg_mode_select = `MODE_AS;
  logic [31:0] wdata = 0, rdata, rd, mem_hdr;
  int          fail_count = 0, n_tests = 0, k;
  row_t        rows [10] = '{
    '{0, `REG_CTRL, 32'h0, 32'h0, `RESP_OKAY}, '{0, `REG_LEN, 32'h0, 32'h0100, `RESP_OKAY},
    '{0, `REG_ADDR, 32'h0, 32'h0, `RESP_OKAY}, '{0, `REG_COUNT, 32'h0, 32'h0, `RESP_OKAY},
    '{0, 8'h18, 32'h0, 32'h0, `RESP_SLVERR}, '{1, 8'h18, 32'hFFFF_FFFF, 32'h0, `RESP_SLVERR},
    '{1, `REG_LEN, 32'hFFFF_0020, 32'h0, `RESP_OKAY}, '{0, `REG_LEN, 32'h0, 32'h0020, `RESP_OKAY},
    '{1, `REG_ADDR, 32'hAB12_3456, 32'h0, `RESP_OKAY},
    '{0, `REG_ADDR, 32'h0, 32'h0012_3456, `RESP_OKAY}};

  always #2.5 aclk = ~aclk;

  config_chain_and_global_override_pins u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cfg_restart_n(cfg_restart_n), .chain_enable_in_n(chain_enable_in_n),
    .chain_enable_out_n(ceo_n), .cfg_mode_select(cfg_mode_select),
    .cfg_serial_clock_in(ps_clk), .cfg_serial_clock_out(sck), .cfg_serial_clock_oe_n(sck_oe_n),
    .cfg_data_in(cfg_mode_select == `MODE_AS ? mem_dout : ps_data),
    .serial_cfg_data_out(sdo), .serial_cfg_data_out_oe_n(sdo_oe_n), .cfg_mem_select_n(cs_n),
    .cfg_mem_select_oe_n(cs_oe_n), .serial_pins_user_io(ser_user), .init_done_out(ido),
    .init_done_oe_n(ido_oe_n), .user_init_clock(uclk), .init_pins_user_io(init_user),
    .global_clear_n(glob_clr_n), .global_output_enable(glob_oe), .clear_all_regs(clr_all),
    .io_tristate_all(tri_all));

  cfg_memory_model #(.WORD(MEM_WORD)) u_mem (
    .sck(sck), .cs_n(cs_n), .din(sdo), .dout(mem_dout), .header(mem_hdr));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic stall;
    fail_count++;
    $display("ERROR %0t: wait ran out", $time);
    test_done;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) stall;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) stall;
    @(posedge aclk);
  endtask

  // w selects the pin: 0 memory select, 1 chain enable output
  task automatic wait_pin(input int w, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && ((w == 0 ? cs_n : ceo_n) !== v); n++) @(posedge aclk);
    if (n == lim) stall;
  endtask

  // external source clocks the frame only while it lasts, then drives data to the inverse of the last bit
  task automatic ps_frame(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ps_data <= w[i];
      repeat (16) @(posedge aclk);
      ps_clk <= 1'b1;
      repeat (16) @(posedge aclk);
      ps_clk <= 1'b0;
    end
    ps_data <= ~w[0];
    @(posedge aclk);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHECK(ceo_n, 1'b1)
    `CHECK(tri_all, 1'b1)
    foreach (rows[i]) begin
      if (rows[i].wr) axi_write(rows[i].a, rows[i].d, rs);
      else begin
        axi_read(rows[i].a, rd, rs);
        `CHECK(rd, rows[i].e)
      end
      `CHECK(rs, rows[i].r)
    end
    // ---------------------------------------------------------------
    // active serial load gated by the chain input
    // ---------------------------------------------------------------
    axi_write(`REG_CTRL, 32'h0000_0007, rs);
    repeat (10) @(posedge aclk);
    `CHECK(cs_n, 1'b1)
    `CHECK(ceo_n, 1'b1)
    chain_enable_in_n <= 1'b0;
    wait_pin(0, 1'b0, 40);
    `CHECK(ido_oe_n, 1'b0)
    `CHECK(sck_oe_n, 1'b0)
    `CHECK(ser_user, 1'b0)
    wait_pin(0, 1'b1, 1000);
    `CHECK(mem_hdr, {`CMD_READ, 24'h12_3456})
    wait_pin(1, 1'b0, 100);
    `CHECK(cs_n, 1'b1)
    `CHECK(init_user, 1'b1)
    `CHECK(ido_oe_n, 1'b1)
    axi_read(`REG_DATA, rd, rs);
    `CHECK(rd, MEM_WORD)
    glob_oe <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHECK(tri_all, 1'b1)
    glob_oe <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHECK(tri_all, 1'b0)
    glob_clr_n <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHECK(clr_all, 1'b1)
    glob_clr_n <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHECK(clr_all, 1'b0)
    // ---------------------------------------------------------------
    // restart into passive serial, init paced by the user clock
    // ---------------------------------------------------------------
    cfg_restart_n <= 1'b0;
    cfg_mode_select <= `MODE_PS;
    repeat (6) @(posedge aclk);
    `CHECK(tri_all, 1'b1)
    `CHECK(ceo_n, 1'b1)
    axi_write(`REG_CTRL, 32'h0000_000F, rs);
    cfg_restart_n <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHECK(ser_user, 1'b1)
    `CHECK(sck_oe_n, 1'b1)
    ps_frame(PS_WORD);
    repeat (40) @(posedge aclk);
    for (k = 0; k < 16; k++) begin
      if (k == 15) `CHECK(ceo_n, 1'b1)
      uclk <= 1'b1;
      repeat (3) @(posedge aclk);
      uclk <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    wait_pin(1, 1'b0, 20);
    cfg_mode_select <= 2'h2;
    repeat (6) @(posedge aclk);
    axi_read(`REG_DATA, rd, rs);
    `CHECK(rd, PS_WORD)
    axi_read(`REG_STATUS, rd, rs);
    `CHECK(rd[5:4], `MODE_PS)
    `CHECK(rd[2:0], 3'h4)
    axi_read(`REG_COUNT, rd, rs);
    `CHECK(rd, 32'h0000_0002)
    // ---------------------------------------------------------------
    // chain input raised in the middle of an active serial load
    // ---------------------------------------------------------------
    cfg_restart_n <= 1'b0;
    cfg_mode_select <= `MODE_AS;
    repeat (6) @(posedge aclk);
    cfg_restart_n <= 1'b1;
    wait_pin(0, 1'b0, 40);
    chain_enable_in_n <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHECK(cs_n, 1'b1)
    axi_read(`REG_STATUS, rd, rs);
    `CHECK({rd[12], rd[2:0]}, 4'h9)
    axi_write(`REG_STATUS, 32'h0000_1000, rs);
    axi_read(`REG_STATUS, rd, rs);
    `CHECK(rd[12], 1'b0)
    test_done;
  end
endmodule // config_chain_and_global_override_pins_bench

bind config_chain_and_global_override_pins cfg_pins_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .cfg_restart_n(cfg_restart_n),
  .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
  .cfg_serial_clock_out(cfg_serial_clock_out), .cfg_serial_clock_oe_n(cfg_serial_clock_oe_n),
  .serial_cfg_data_out(serial_cfg_data_out),
  .serial_cfg_data_out_oe_n(serial_cfg_data_out_oe_n), .cfg_mem_select_n(cfg_mem_select_n),
  .cfg_mem_select_oe_n(cfg_mem_select_oe_n), .serial_pins_user_io(serial_pins_user_io),
  .init_done_oe_n(init_done_oe_n), .init_pins_user_io(init_pins_user_io),
  .global_clear_n(global_clear_n), .clear_all_regs(clear_all_regs),
  .io_tristate_all(io_tristate_all));
